/* verilog/tccu_pkg.sv */
/*
   constants shared by the timer capture/compare unit: register addresses,
   field positions, masks and reset values.
   assumes an 8-bit special function register bus with one access per machine cycle.
*/
package tccu_pkg;
   localparam int unsigned NUM_CAP  = 4;
   localparam int unsigned NUM_CMP  = 3;
   localparam int unsigned TMR_W    = 16;
   localparam int unsigned NUM_IRQ  = 9;

   // -------------------------------------------------------------
   // register addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CAP_BASE   = 8'ha0;   // capture n low at base+2n, high at base+2n+1
   localparam logic [7:0] ADDR_CMP_BASE   = 8'hb0;   // compare n low at base+2n, high at base+2n+1
   localparam logic [7:0] ADDR_PORT       = 8'hc0;
   localparam logic [7:0] ADDR_IRQ_FLAG   = 8'hc8;
   localparam logic [7:0] ADDR_IRQ_EN     = 8'he8;
   localparam logic [7:0] ADDR_TMR_CTRL   = 8'hea;
   localparam logic [7:0] ADDR_CAP_EDGE   = 8'heb;
   localparam logic [7:0] ADDR_SET_EN     = 8'hee;
   localparam logic [7:0] ADDR_RST_TOG_EN = 8'hef;
   localparam logic [7:0] ADDR_IRQ_PRIO   = 8'hf8;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int unsigned FLAG_CMP_LSB   = 4;     // flag bits 6:4 are the compare flags
   localparam int unsigned FLAG_WIDE_OVF  = 7;
   localparam int unsigned CTRL_BYTE_OVF  = 4;
   localparam int unsigned EN_OVF         = 7;     // one enable/priority bit covers both overflows
   localparam int unsigned TOG_LO         = 6;
   localparam int unsigned TOG_HI         = 7;
   localparam int unsigned CMP_SET        = 0;
   localparam int unsigned CMP_CLR        = 1;
   localparam int unsigned CMP_TOG        = 2;
   localparam int unsigned IRQ_BYTE_OVF   = 8;

   // -------------------------------------------------------------
   // masks and reset values
   // -------------------------------------------------------------
   localparam logic [7:0]  LOW_PORT_MASK  = 8'h3f;
   localparam logic [7:0]  HI_PORT_MASK   = 8'hc0;
   localparam logic [1:0]  TOG_RESET      = 2'h3;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;
   localparam logic [15:0] WORD_ZERO      = 16'h0000;
endpackage : tccu_pkg

/* verilog/tccu_cmp_if.sv */
/*
   carrier between the top and its comparator bank.
   assumes both ends run on the same machine-cycle clock.
*/
`timescale 1ns/10ps
interface tccu_cmp_if;
   import tccu_pkg::*;
   logic [TMR_W-1:0] timer;
   logic             timer_inc;
   logic [TMR_W-1:0] cmp_val [NUM_CMP];
   logic [NUM_CMP-1:0] match;

   modport ctrl (output timer, output timer_inc, output cmp_val, input match);
   modport bank (input timer, input timer_inc, input cmp_val, output match);
endinterface : tccu_cmp_if

/* verilog/tccu_cmp_bank.sv */
/*
   comparator bank: one equality comparator per compare register.
   assumes timer carries the already incremented value while timer_inc is high.
*/
`timescale 1ns/10ps
module tccu_cmp_bank
   import tccu_pkg::*;
#(
   parameter int unsigned N_CMP = NUM_CMP
)
(
   tccu_cmp_if.bank cmp_bus
);
   // -------------------------------------------------------------
   // elaboration check
   // -------------------------------------------------------------
   if (N_CMP != NUM_CMP)
   begin : g_bad_count
      $error("comparator count must match the register map");
   end

   // -------------------------------------------------------------
   // comparators
   // -------------------------------------------------------------
   // combinational so that the match is known in the increment cycle itself
   for (genvar g = 0; g < N_CMP; g++)
   begin : g_cmp
      assign cmp_bus.match[g] = cmp_bus.timer_inc && (cmp_bus.timer == cmp_bus.cmp_val[g]);
   end
endmodule : tccu_cmp_bank

/* verilog/tccu_top.sv */
/*
   timer capture/compare unit: capture registers, compare registers, output port
   latch, toggle flip-flops, timer interrupt flags with enables and priorities.
   assumes the timer itself lives outside and supplies its value, an increment
   strobe and overflow strobes; one clock edge is one machine cycle.
*/
`timescale 1ns/10ps
module tccu_top
   import tccu_pkg::*;
#(
   parameter int unsigned N_CAP = NUM_CAP
)
(
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   input  wire logic [7:0]          sfr_addr_i,
   input  wire logic [7:0]          sfr_wdata_i,
   input  wire logic                sfr_wr_i,
   input  wire logic                sfr_rd_i,
   output      logic [7:0]          sfr_rdata_o,
   input  wire logic [TMR_W-1:0]    timer_i,
   input  wire logic                timer_inc_i,
   input  wire logic                wide_ovf_i,
   input  wire logic                byte_ovf_i,
   input  wire logic [N_CAP-1:0]    capture_in_i,
   output      logic [7:0]          port_o,
   output      logic [NUM_IRQ-1:0]  irq_o,
   output      logic [NUM_IRQ-1:0]  irq_prio_o
);
   // -------------------------------------------------------------
   // elaboration check
   // -------------------------------------------------------------
   if (N_CAP != NUM_CAP)
   begin : g_bad_count
      $error("capture channel count must match the register map");
   end

   // -------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------
   function automatic logic edge_hit(input logic [7:0] sel, input int unsigned ch,
                                     input logic now, input logic was);
      logic rise;
      logic fall;
      rise = now & ~was;
      fall = ~now & was;
      return (rise & sel[2*ch]) | (fall & sel[2*ch+1]);
   endfunction : edge_hit

   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] target);
      return wr && (a == target);
   endfunction : wr_hit

   // -------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [7:0]         cap_edge;
   logic [5:0]         set_en;
   logic [7:0]         rst_tog_en;
   logic [7:0]         irq_en;
   logic [7:0]         irq_prio;
   logic [7:0]         irq_flag;
   logic               byte_ovf_flag;
   logic [1:0]         tog_state;
   logic [7:0]         port_latch;
   logic [TMR_W-1:0]   cmp_reg [NUM_CMP];
   logic [TMR_W-1:0]   cap_reg [NUM_CAP];
   logic [NUM_CMP-1:0] match_d;
   logic [7:0]         next_flag;
   logic [7:0]         next_en;
   logic               next_byte_ovf;
   logic [7:0]         next_port;
   logic [1:0]         next_tog;
   logic [NUM_CAP-1:0] cap_hit;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_edge   <= BYTE_ZERO;
         set_en     <= LOW_PORT_MASK[5:0] & BYTE_ZERO[5:0];
         rst_tog_en <= BYTE_ZERO;
         irq_en     <= BYTE_ZERO;
         irq_prio   <= BYTE_ZERO;
      end
      else
      begin
         if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_CAP_EDGE))
            cap_edge <= sfr_wdata_i;
         if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_SET_EN))
            set_en <= sfr_wdata_i[5:0];   // bits 7,6 are read only
         if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_RST_TOG_EN))
            rst_tog_en <= sfr_wdata_i;
         if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_IRQ_EN))
            irq_en <= sfr_wdata_i;
         if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_IRQ_PRIO))
            irq_prio <= sfr_wdata_i;
      end
   end

   // compare registers, byte-wide halves
   for (genvar g = 0; g < NUM_CMP; g++)
   begin : g_cmp_reg
      localparam logic [7:0] A_LO = ADDR_CMP_BASE + 8'(2*g);
      localparam logic [7:0] A_HI = ADDR_CMP_BASE + 8'(2*g+1);
      always_ff @(posedge clk_i or negedge rst_n)
      begin
         if (!rst_n)
            cmp_reg[g] <= WORD_ZERO;
         else
         begin
            if (wr_hit(sfr_wr_i, sfr_addr_i, A_LO))
               cmp_reg[g][7:0] <= sfr_wdata_i;
            if (wr_hit(sfr_wr_i, sfr_addr_i, A_HI))
               cmp_reg[g][15:8] <= sfr_wdata_i;
         end
      end
   end

   // -------------------------------------------------------------
   // comparator bank
   // -------------------------------------------------------------
   tccu_cmp_if cmp_bus ();

   assign cmp_bus.timer     = timer_i;
   assign cmp_bus.timer_inc = timer_inc_i;
   for (genvar g = 0; g < NUM_CMP; g++)
   begin : g_cmp_wire
      assign cmp_bus.cmp_val[g] = cmp_reg[g];
   end

   tccu_cmp_bank #(
      .N_CMP (NUM_CMP)
   ) u_cmp_bank (
      .cmp_bus (cmp_bus.bank)
   );

   // -------------------------------------------------------------
   // capture inputs
   // -------------------------------------------------------------
   // two flops for metastability, a third holds last cycle's sample
   logic [NUM_CAP-1:0] cap_meta;
   logic [NUM_CAP-1:0] cap_sync;
   logic [NUM_CAP-1:0] cap_prev;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_meta <= '0;
         cap_sync <= '0;
         cap_prev <= '0;
      end
      else
      begin
         cap_meta <= capture_in_i;
         cap_sync <= cap_meta;
         cap_prev <= cap_sync;
      end
   end

   for (genvar g = 0; g < NUM_CAP; g++)
   begin : g_cap
      assign cap_hit[g] = edge_hit(cap_edge, g, cap_sync[g], cap_prev[g]);
      always_ff @(posedge clk_i or negedge rst_n)
      begin
         if (!rst_n)
            cap_reg[g] <= WORD_ZERO;
         else if (cap_hit[g])
            cap_reg[g] <= timer_i;   // captured at the end of the detecting cycle
      end
   end

   // -------------------------------------------------------------
   // interrupt flags
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         match_d <= '0;
      else
         match_d <= cmp_bus.match;
   end

   // enable written this cycle already gates the request, so a request follows an enable write on that write's edge
   assign next_en = wr_hit(sfr_wr_i, sfr_addr_i, ADDR_IRQ_EN) ? sfr_wdata_i : irq_en;

   // a hardware set beats a software clear in the same cycle
   always_comb
   begin
      next_flag     = irq_flag;
      next_byte_ovf = byte_ovf_flag;
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_IRQ_FLAG))
         next_flag = sfr_wdata_i;
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_TMR_CTRL))
         next_byte_ovf = sfr_wdata_i[CTRL_BYTE_OVF];
      next_flag[NUM_CAP-1:0] = next_flag[NUM_CAP-1:0] | cap_hit;
      next_flag[FLAG_CMP_LSB +: NUM_CMP] = next_flag[FLAG_CMP_LSB +: NUM_CMP] | match_d;
      next_flag[FLAG_WIDE_OVF] = next_flag[FLAG_WIDE_OVF] | wide_ovf_i;
      next_byte_ovf = next_byte_ovf | byte_ovf_i;
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_flag      <= BYTE_ZERO;
         byte_ovf_flag <= 1'b0;
      end
      else
      begin
         irq_flag      <= next_flag;
         byte_ovf_flag <= next_byte_ovf;
      end
   end

   // requests follow the flags in the same cycle by using the next values
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_o      <= '0;
         irq_prio_o <= '0;
      end
      else
      begin
         irq_o[7:0]         <= next_flag & next_en;
         irq_o[IRQ_BYTE_OVF] <= next_byte_ovf & next_en[EN_OVF];
         if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_IRQ_PRIO))
         begin
            irq_prio_o[7:0]          <= sfr_wdata_i;
            irq_prio_o[IRQ_BYTE_OVF] <= sfr_wdata_i[EN_OVF];
         end
      end
   end

   // -------------------------------------------------------------
   // output port latch and toggle flip-flops
   // -------------------------------------------------------------
   always_comb
   begin
      next_port = port_latch;
      next_tog  = tog_state;
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_PORT))
         next_port = sfr_wdata_i;
      // match updates applied after the software write so they take precedence
      if (cmp_bus.match[CMP_SET])
         next_port[5:0] = next_port[5:0] | set_en;
      if (cmp_bus.match[CMP_CLR])
         next_port[5:0] = next_port[5:0] & ~rst_tog_en[5:0];   // clear last so it wins
      if (cmp_bus.match[CMP_TOG])
      begin
         if (rst_tog_en[TOG_LO])
         begin
            next_port[TOG_LO] = tog_state[0];
            next_tog[0]       = ~tog_state[0];
         end
         if (rst_tog_en[TOG_HI])
         begin
            next_port[TOG_HI] = tog_state[1];
            next_tog[1]       = ~tog_state[1];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_latch <= BYTE_ZERO;
         port_o     <= BYTE_ZERO;
         tog_state  <= TOG_RESET;   // first toggle sets the latch
      end
      else
      begin
         port_latch <= next_port;
         port_o     <= next_port;   // pin updates on the same edge as the latch for both sources
         tog_state  <= next_tog;
      end
   end

   // -------------------------------------------------------------
   // register read
   // -------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb
   begin
      rd_mux = BYTE_ZERO;
      case (sfr_addr_i)
         ADDR_CAP_EDGE   : rd_mux = cap_edge;
         ADDR_SET_EN     : rd_mux = {tog_state, set_en};
         ADDR_RST_TOG_EN : rd_mux = rst_tog_en;
         ADDR_IRQ_EN     : rd_mux = irq_en;
         ADDR_IRQ_PRIO   : rd_mux = irq_prio;
         ADDR_IRQ_FLAG   : rd_mux = irq_flag;
         ADDR_TMR_CTRL   : rd_mux = BYTE_ZERO | (8'(byte_ovf_flag) << CTRL_BYTE_OVF);
         ADDR_PORT       : rd_mux = port_latch;
         default         : rd_mux = BYTE_ZERO;
      endcase
      for (int i = 0; i < NUM_CAP; i++)
      begin
         if (sfr_addr_i == ADDR_CAP_BASE + 8'(2*i))
            rd_mux = cap_reg[i][7:0];
         if (sfr_addr_i == ADDR_CAP_BASE + 8'(2*i+1))
            rd_mux = cap_reg[i][15:8];
      end
      for (int i = 0; i < NUM_CMP; i++)
      begin
         if (sfr_addr_i == ADDR_CMP_BASE + 8'(2*i))
            rd_mux = cmp_reg[i][7:0];
         if (sfr_addr_i == ADDR_CMP_BASE + 8'(2*i+1))
            rd_mux = cmp_reg[i][15:8];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         sfr_rdata_o <= BYTE_ZERO;
      else if (sfr_rd_i)
         sfr_rdata_o <= rd_mux;
   end
endmodule : tccu_top

/* test/tccu_top_sva.sv */
/*
   checker for the timer capture/compare unit, bound to the top module.
   assumes one clock and the asynchronous active low reset input.
*/
`timescale 1ns/10ps
module tccu_top_sva
   import tccu_pkg::*;
#(
   parameter int unsigned N_CAP = NUM_CAP
)
(
   input wire logic                clk_i,
   input wire logic                resetn_i,
   input wire logic [7:0]          sfr_addr_i,
   input wire logic [7:0]          sfr_wdata_i,
   input wire logic                sfr_wr_i,
   input wire logic                sfr_rd_i,
   input wire logic [7:0]          sfr_rdata_o,
   input wire logic [TMR_W-1:0]    timer_i,
   input wire logic                timer_inc_i,
   input wire logic                wide_ovf_i,
   input wire logic                byte_ovf_i,
   input wire logic [N_CAP-1:0]    capture_in_i,
   input wire logic [7:0]          port_o,
   input wire logic [NUM_IRQ-1:0]  irq_o,
   input wire logic [NUM_IRQ-1:0]  irq_prio_o
);
   // ---------------------------------------------------------
   // helper: cycles since a capture pin last moved
   // ---------------------------------------------------------
   logic [N_CAP-1:0] cap_q;
   logic [3:0]       quiet;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cap_q <= '0;
         quiet <= 4'hf;
      end
      else
      begin
         cap_q <= capture_in_i;
         quiet <= (cap_q != capture_in_i) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
      end
   end

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   port_cause_a: assert property (!$past(sfr_wr_i) && !$past(timer_inc_i) |-> $stable(port_o))
      else $error("port moved without write or timer step");
   cmp_flag_cause_a: assert property ((irq_o[6:4] & ~$past(irq_o[6:4])) != 3'h0
      |-> $past(timer_inc_i, 2) || $past(sfr_wr_i))
      else $error("compare request without a match two cycles back");
   wide_ovf_cause_a: assert property ($rose(irq_o[7]) |-> $past(wide_ovf_i) || $past(sfr_wr_i))
      else $error("wide overflow request without cause");
   byte_ovf_cause_a: assert property ($rose(irq_o[8]) |-> $past(byte_ovf_i) || $past(sfr_wr_i))
      else $error("byte overflow request without cause");
   cap_flag_cause_a: assert property ((irq_o[3:0] & ~$past(irq_o[3:0])) != 4'h0
      |-> quiet < 4'h6 || $past(sfr_wr_i))
      else $error("capture request without pin edge");
   flags_hold_a: assert property (!$past(sfr_wr_i) |-> (~irq_o & $past(irq_o)) == 9'h000)
      else $error("request dropped without software write");
   prio_hold_a: assert property (!$past(sfr_wr_i) |-> $stable(irq_prio_o))
      else $error("priority changed without write");
   rdata_hold_a: assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
      else $error("read data changed without read");

   cover property (irq_o[4]);
   cover property ($rose(port_o[6]));
   cover property (irq_o[0] && irq_o[2]);
   cover property (irq_o[8]);
endmodule : tccu_top_sva

bind tccu_top tccu_top_sva #(.N_CAP(N_CAP)) tccu_top_sva_i (
   .clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .timer_i(timer_i),
   .timer_inc_i(timer_inc_i), .wide_ovf_i(wide_ovf_i), .byte_ovf_i(byte_ovf_i),
   .capture_in_i(capture_in_i), .port_o(port_o), .irq_o(irq_o), .irq_prio_o(irq_prio_o));

/* test/testbench.sv */
/*
   self-checking bench: register, compare, toggle, overflow and capture runs.
   assumes the checker binds itself to the top module.
*/
`timescale 1ns/10ps
module testbench;
   import tccu_pkg::*;
   logic         clk_i        = 1'b0;
   logic         resetn_i     = 1'b0;
   logic [7:0]   sfr_addr_i   = 8'h00;
   logic [7:0]   sfr_wdata_i  = 8'h00;
   logic         sfr_wr_i     = 1'b0;
   logic         sfr_rd_i     = 1'b0;
   logic [15:0]  timer_i      = 16'h0000;
   logic         timer_inc_i  = 1'b0;
   logic         wide_ovf_i   = 1'b0;
   logic         byte_ovf_i   = 1'b0;
   logic [3:0]   capture_in_i = 4'h0;
   logic [7:0]   sfr_rdata_o;
   logic [7:0]   port_o;
   logic [8:0]   irq_o;
   logic [8:0]   irq_prio_o;
   int           n_fail       = 0;
   int           checks       = 0;

   tccu_top tccu_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
      .timer_i(timer_i), .timer_inc_i(timer_inc_i), .wide_ovf_i(wide_ovf_i), .byte_ovf_i(byte_ovf_i),
      .capture_in_i(capture_in_i), .port_o(port_o), .irq_o(irq_o), .irq_prio_o(irq_prio_o));

   always #10 clk_i = ~clk_i;

   // ---------------------------------------------------------
   // tasks
   // ---------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one machine cycle of bus and timer activity, then the edge that takes it
   task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
                     input logic inc, input logic [15:0] tv);
      @(posedge clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= w;
      sfr_rd_i    <= r;
      timer_inc_i <= inc;
      timer_i     <= tv;
      @(posedge clk_i);
      sfr_wr_i    <= 1'b0;
      sfr_rd_i    <= 1'b0;
      timer_inc_i <= 1'b0;
      #1;
   endtask : op

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(a, d, 1'b1, 1'b0, 1'b0, timer_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      op(a, 8'h00, 1'b0, 1'b1, 1'b0, timer_i);
      chk(16'(sfr_rdata_o), 16'(e));
   endtask : rd

   task automatic tick(input logic [15:0] v);
      op(sfr_addr_i, 8'h00, 1'b0, 1'b0, 1'b1, v);
   endtask : tick

   task automatic step;
      @(posedge clk_i);
      #1;
   endtask : step

   // bounded wait; the pins pass two sync flops first
   task automatic wait_cap;
      for (int i = 0; i < 10 && irq_o[3:0] === 4'h0; i++)
         step();
      if (irq_o[3:0] === 4'h0)
      begin
         n_fail++;
         $display("MISMATCH at %0t: no capture request", $time);
         final_report();
      end
   endtask : wait_cap

   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      $display("MISMATCH at %0t: run hung", $time);
      final_report();
   end

   // ---------------------------------------------------------
   // sequence
   // ---------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 6; i++)
         rd(ADDR_CMP_BASE + 8'(i), 8'h00);
      rd(8'h10, 8'h00);
      wr(ADDR_SET_EN, 8'h15);
      rd(ADDR_SET_EN, 8'hd5);
      $display("test registers done");

      wr(ADDR_CMP_BASE, 8'h10);
      wr(ADDR_CMP_BASE + 8'h02, 8'h20);
      wr(ADDR_RST_TOG_EN, 8'h03);
      wr(ADDR_IRQ_EN, 8'h10);
      tick(16'h0010);
      chk(16'(port_o), 16'h0015);
      chk(16'(irq_o), 16'h0000);
      step();
      chk(16'(irq_o), 16'h0010);
      tick(16'h0020);
      chk(16'(port_o), 16'h0014);
      step();
      chk(16'(irq_o), 16'h0010);
      rd(ADDR_IRQ_FLAG, 8'h30);
      wr(ADDR_CMP_BASE + 8'h02, 8'h10);
      wr(ADDR_RST_TOG_EN, 8'h01);
      tick(16'h0010);
      chk(16'(port_o), 16'h0014);
      $display("test compare done");

      wr(ADDR_RST_TOG_EN, 8'hc0);
      wr(ADDR_CMP_BASE + 8'h04, 8'h30);
      tick(16'h0030);
      chk(16'(port_o), 16'h00d4);
      rd(ADDR_SET_EN, 8'h15);
      wr(ADDR_PORT, 8'h14);
      chk(16'(port_o), 16'h0014);
      tick(16'h0030);
      chk(16'(port_o), 16'h0014);
      rd(ADDR_SET_EN, 8'hd5);
      op(ADDR_PORT, 8'h00, 1'b1, 1'b0, 1'b1, 16'h0030);
      chk(16'(port_o), 16'h00c0);
      $display("test toggle done");

      wr(ADDR_IRQ_EN, 8'h80);
      wr(ADDR_IRQ_PRIO, 8'h81);
      chk(16'(irq_prio_o), 16'h0181);
      @(posedge clk_i);
      wide_ovf_i <= 1'b1;
      byte_ovf_i <= 1'b1;
      @(posedge clk_i);
      wide_ovf_i <= 1'b0;
      byte_ovf_i <= 1'b0;
      #1;
      chk(16'(irq_o), 16'h0180);
      rd(ADDR_TMR_CTRL, 8'h10);
      rd(ADDR_IRQ_FLAG, 8'hf0);
      wr(ADDR_IRQ_FLAG, 8'h00);
      wr(ADDR_TMR_CTRL, 8'h00);
      chk(16'(irq_o), 16'h0000);
      $display("test overflow done");

      wr(ADDR_CAP_EDGE, 8'h39);
      wr(ADDR_IRQ_EN, 8'h0f);
      op(ADDR_IRQ_EN, 8'h00, 1'b0, 1'b0, 1'b0, 16'h1234);
      @(posedge clk_i);
      capture_in_i <= 4'h7;
      wait_cap();
      chk(16'(irq_o), 16'h0005);
      rd(ADDR_CAP_BASE, 8'h34);
      rd(ADDR_CAP_BASE + 8'h01, 8'h12);
      rd(ADDR_CAP_BASE + 8'h04, 8'h34);
      wr(ADDR_CAP_BASE, 8'hff);
      rd(ADDR_CAP_BASE, 8'h34);
      wr(ADDR_IRQ_FLAG, 8'h00);
      op(ADDR_IRQ_EN, 8'h00, 1'b0, 1'b0, 1'b0, 16'h5678);
      @(posedge clk_i);
      capture_in_i <= 4'h0;
      wait_cap();
      chk(16'(irq_o), 16'h0006);
      rd(ADDR_CAP_BASE + 8'h02, 8'h78);
      rd(ADDR_CAP_BASE + 8'h03, 8'h56);
      rd(ADDR_CAP_BASE, 8'h34);
      $display("test capture done");
      final_report();
   end
endmodule : testbench
